// file: hw/power_class_default_select.sv
// Contract
// RL1: Straps give default self-ID power field.
// RL2: Catch strap code after every hardware reset.
// RL3: Software write replaces the strap default.
// RL4: Code 000: no power needed or repeated.
// RL5: Codes 001-011: self powered, 15/30/45 W.
// RL6: Code 100: may draw bus, up to 3W.
// RL7: Codes 101-111: bus powered, link 0/3/7 W.
// RL8: Active code held until write or reset.
`timescale 1ns/100ps
`default_nettype none

module power_class_default_select (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Board straps
  input wire logic [pcds_pkg::CODE_W-1:0] powerClassStraps,
  // Software write of the power-class setting
  input wire logic pwrClassWrite,
  input wire logic [pcds_pkg::CODE_W-1:0] pwrClassWrData,
  // Self-ID word from the packet generator
  input wire logic selfIdValid,
  input wire logic [pcds_pkg::WORD_W-1:0] selfIdWord,
  // Self-ID word with the power field filled
  output logic selfIdOutValid,
  output logic [pcds_pkg::WORD_W-1:0] selfIdOutWord,
  // Active code and its meaning
  output logic [pcds_pkg::CODE_W-1:0] powerClass,
  output pcds_pkg::pcds_class_info_type classInfo,
  output logic classLoaded,
  output logic classFromSoftware
);

  // Controller state
  pcds_pkg::pcds_state_type state_r;
  pcds_pkg::pcds_state_type state_nxt;
  // Active power-class value
  logic [pcds_pkg::CODE_W-1:0] powerClass_r;
  logic [pcds_pkg::CODE_W-1:0] powerClass_nxt;
  // Source of the active value
  logic fromSw_r;
  logic fromSw_nxt;
  logic loaded_r;
  // Registered meaning, aligned with powerClass_r
  pcds_pkg::pcds_class_info_type info_r;
  pcds_pkg::pcds_class_info_type infoNxt;
  // Output word path
  logic outValid_r;
  logic [pcds_pkg::WORD_W-1:0] outWord_r;
  logic [pcds_pkg::WORD_W-1:0] outWord_nxt;

  // Decode wires
  wire inLoad = (state_r == pcds_pkg::ST_LOAD);
  // Strap capture is the first clocked step after reset release
  wire strapTake = inLoad && !pwrClassWrite;

  // Next state: leave load after one edge
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pcds_pkg::ST_LOAD: state_nxt = pcds_pkg::ST_RUN;
      pcds_pkg::ST_RUN: state_nxt = pcds_pkg::ST_RUN;
      default: state_nxt = pcds_pkg::ST_LOAD; // Illegal code recovers via reload
    endcase
  end

  // Value selection; a write in the load cycle wins, being later in intent
  assign powerClass_nxt = pwrClassWrite ? pwrClassWrData : // [RL3]
                          strapTake ? powerClassStraps : // [RL2]
                          powerClass_r; // [RL8]
  assign fromSw_nxt = pwrClassWrite ? 1'b1 : (strapTake ? 1'b0 : fromSw_r); // [RL3]

  // Meaning of the next value, so info_r tracks powerClass_r
  pcds_class_decode uDecode (
    .code(powerClass_nxt),
    .info(infoNxt)
  );

  // Self-ID word with the power field replaced; uses the value already active
  always_comb begin
    outWord_nxt = selfIdWord;
    outWord_nxt[pcds_pkg::PWR_MSB:pcds_pkg::PWR_LSB] = powerClass_r; // [RL1]
  end

  // State register; async reset forces a reload of the straps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= pcds_pkg::ST_LOAD; // [RL2]
    end else begin
      state_r <= state_nxt;
    end
  end

  // Active value; straps are never sampled under reset itself
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerClass_r <= pcds_pkg::PC_RESET;
      fromSw_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      powerClass_r <= powerClass_nxt; // [RL8]
      fromSw_r <= fromSw_nxt;
      loaded_r <= 1'b1;
    end
  end

  // Registered meaning of the active code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      info_r <= '0;
    end else begin
      info_r <= infoNxt;
    end
  end

  // Word path; one cycle of latency, no buffering
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid_r <= 1'b0;
      outWord_r <= '0;
    end else begin
      outValid_r <= selfIdValid;
      outWord_r <= outWord_nxt; // [RL1]
    end
  end

  // Outputs straight from flops
  assign selfIdOutValid = outValid_r;
  assign selfIdOutWord = outWord_r;
  assign powerClass = powerClass_r;
  assign classInfo = info_r;
  assign classLoaded = loaded_r;
  assign classFromSoftware = fromSw_r;

  // Field carries the active code one cycle later
  AST_FIELD_CODE: assert property ( // [RL1]
    @(posedge clk) disable iff (!resetn)
    selfIdValid |=> selfIdOutValid &&
      (selfIdOutWord[pcds_pkg::PWR_MSB:pcds_pkg::PWR_LSB] == $past(powerClass_r)))
    else $error("power field does not carry active code");

  // Other word bits pass untouched
  AST_FIELD_KEEP: assert property ( // [RL1]
    @(posedge clk) disable iff (!resetn)
    selfIdValid |=> (selfIdOutWord[pcds_pkg::PWR_LSB-1:0] ==
      $past(selfIdWord[pcds_pkg::PWR_LSB-1:0]))
      && (selfIdOutWord[pcds_pkg::WORD_W-1:pcds_pkg::PWR_MSB+1] ==
      $past(selfIdWord[pcds_pkg::WORD_W-1:pcds_pkg::PWR_MSB+1])))
    else $error("self-ID bits outside power field altered");

  // Straps become active after reset release
  AST_STRAP_LOAD: assert property ( // [RL2]
    @(posedge clk) disable iff (!resetn)
    // Sampled resetn keeps the release edge itself out of the antecedent
    (resetn && inLoad && !pwrClassWrite) |=> (powerClass_r == $past(powerClassStraps))
      && !classFromSoftware && classLoaded)
    else $error("strap default not loaded after reset");

  // Software write takes over next cycle
  AST_SW_WRITE: assert property ( // [RL3]
    @(posedge clk) disable iff (!resetn)
    pwrClassWrite |=> (powerClass_r == $past(pwrClassWrData)) && classFromSoftware)
    else $error("software power-class write not applied");

  // Code 000 neither needs nor repeats power
  AST_CODE_NONE: assert property ( // [RL4]
    @(posedge clk) disable iff (!resetn)
    (powerClass_r == pcds_pkg::PC_NO_POWER) |->
      !classInfo.needsPower && !classInfo.repeatsPower)
    else $error("code 000 meaning wrong");

  // Self-powered code 010 gives the 30 W minimum supply
  AST_CODE_SELF: assert property ( // [RL5]
    @(posedge clk) disable iff (!resetn)
    (powerClass_r == pcds_pkg::PC_SELF_30W) |->
      classInfo.selfPowered && (classInfo.supplyMinW == pcds_pkg::SUPPLY_30W))
    else $error("self-powered 30 W meaning wrong");

  // Optional bus power limited to 3 W
  AST_CODE_MAY: assert property ( // [RL6]
    @(posedge clk) disable iff (!resetn)
    (powerClass_r == pcds_pkg::PC_BUS_MAY) |->
      classInfo.busOptional && !classInfo.busPowered
      && (classInfo.drawMaxW == pcds_pkg::DRAW_3W))
    else $error("code 100 meaning wrong");

  // Bus-powered code 111 needs 7 W link extra and draws up to 3 W
  AST_CODE_BUS: assert property ( // [RL7]
    @(posedge clk) disable iff (!resetn)
    (powerClass_r == pcds_pkg::PC_BUS_LINK7) |->
      classInfo.busPowered && (classInfo.linkExtraW == pcds_pkg::LINK_7W)
      && (classInfo.drawMaxW == pcds_pkg::DRAW_3W))
    else $error("code 111 meaning wrong");

  // Value holds with no write once running
  AST_HOLD: assert property ( // [RL8]
    @(posedge clk) disable iff (!resetn)
    (!inLoad && !pwrClassWrite) |=> $stable(powerClass_r) && $stable(classFromSoftware))
    else $error("active power class changed without a write");

endmodule // power_class_default_select

`default_nettype wire

// file: common/pcds_pkg.sv
`default_nettype none

package pcds_pkg;

  // Width of the power-class code and of a self-ID packet word
  localparam int CODE_W = 3;
  localparam int WORD_W = 32;

  // Power field sits at packet bits 21..23, counted from the MSB as bit 0
  localparam int PWR_FIELD_FIRST = 21;
  localparam int PWR_FIELD_LAST = 23;
  localparam int PWR_LSB = WORD_W - 1 - PWR_FIELD_LAST;
  localparam int PWR_MSB = WORD_W - 1 - PWR_FIELD_FIRST;

  // Power-class codes
  localparam logic [CODE_W-1:0] PC_NO_POWER = 3'h0;
  localparam logic [CODE_W-1:0] PC_SELF_15W = 3'h1;
  localparam logic [CODE_W-1:0] PC_SELF_30W = 3'h2;
  localparam logic [CODE_W-1:0] PC_SELF_45W = 3'h3;
  localparam logic [CODE_W-1:0] PC_BUS_MAY = 3'h4;
  localparam logic [CODE_W-1:0] PC_BUS_LINK0 = 3'h5;
  localparam logic [CODE_W-1:0] PC_BUS_LINK3 = 3'h6;
  localparam logic [CODE_W-1:0] PC_BUS_LINK7 = 3'h7;

  // Reset value of the active code before straps are caught
  localparam logic [CODE_W-1:0] PC_RESET = 3'h0;

  // Wattage figures in whole watts
  localparam logic [5:0] SUPPLY_NONE = 6'h00;
  localparam logic [5:0] SUPPLY_15W = 6'h0f;
  localparam logic [5:0] SUPPLY_30W = 6'h1e;
  localparam logic [5:0] SUPPLY_45W = 6'h2d;
  localparam logic [3:0] DRAW_NONE = 4'h0;
  localparam logic [3:0] DRAW_3W = 4'h3;
  localparam logic [3:0] LINK_NONE = 4'h0;
  localparam logic [3:0] LINK_3W = 4'h3;
  localparam logic [3:0] LINK_7W = 4'h7;

  // Meaning of one power-class code
  typedef struct packed {
    logic needsPower;        // Node takes power from the bus
    logic repeatsPower;      // Node passes or supplies bus power
    logic selfPowered;       // Node has its own supply
    logic busPowered;        // Node is definitely bus powered
    logic busOptional;       // Node may be bus powered
    logic [5:0] supplyMinW;  // Least power given to the bus
    logic [3:0] drawMaxW;    // Most power taken from the bus
    logic [3:0] linkExtraW;  // Extra power needed to enable the link
  } pcds_class_info_type;

  // Controller states, one-hot
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } pcds_state_type;

endpackage

`default_nettype wire

// file: hw/pcds_class_decode.sv
`timescale 1ns/100ps
`default_nettype none

module pcds_class_decode (
  // Code in
  input wire logic [pcds_pkg::CODE_W-1:0] code,
  // Meaning out
  output pcds_pkg::pcds_class_info_type info
);

  // Pure table lookup; every code is legal so no default
  always_comb begin
    info = '0;
    unique case (code)
      pcds_pkg::PC_NO_POWER: begin // [RL4]
        info.needsPower = 1'b0;
        info.repeatsPower = 1'b0;
      end
      pcds_pkg::PC_SELF_15W: begin // [RL5]
        info.selfPowered = 1'b1;
        info.repeatsPower = 1'b1;
        info.supplyMinW = pcds_pkg::SUPPLY_15W;
      end
      pcds_pkg::PC_SELF_30W: begin // [RL5]
        info.selfPowered = 1'b1;
        info.repeatsPower = 1'b1;
        info.supplyMinW = pcds_pkg::SUPPLY_30W;
      end
      pcds_pkg::PC_SELF_45W: begin // [RL5]
        info.selfPowered = 1'b1;
        info.repeatsPower = 1'b1;
        info.supplyMinW = pcds_pkg::SUPPLY_45W;
      end
      pcds_pkg::PC_BUS_MAY: begin // [RL6]
        info.busOptional = 1'b1;
        info.needsPower = 1'b1;
        info.drawMaxW = pcds_pkg::DRAW_3W;
      end
      pcds_pkg::PC_BUS_LINK0: begin // [RL7]
        info.busPowered = 1'b1;
        info.needsPower = 1'b1;
        info.drawMaxW = pcds_pkg::DRAW_3W;
        info.linkExtraW = pcds_pkg::LINK_NONE;
      end
      pcds_pkg::PC_BUS_LINK3: begin // [RL7]
        info.busPowered = 1'b1;
        info.needsPower = 1'b1;
        info.drawMaxW = pcds_pkg::DRAW_3W;
        info.linkExtraW = pcds_pkg::LINK_3W;
      end
      pcds_pkg::PC_BUS_LINK7: begin // [RL7]
        info.busPowered = 1'b1;
        info.needsPower = 1'b1;
        info.drawMaxW = pcds_pkg::DRAW_3W;
        info.linkExtraW = pcds_pkg::LINK_7W;
      end
    endcase
  end

endmodule // pcds_class_decode

`default_nettype wire

// file: testbench/pcds_far_side.sv
`timescale 1ns/100ps
`default_nettype none

module pcds_far_side (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic [2:0] strapCode,
  input wire logic sendReq,
  input wire logic [31:0] sendWord,
  // Pins toward the block
  output logic [2:0] powerClassStraps,
  output logic selfIdValid,
  output logic [31:0] selfIdWord
);
  logic [31:0] idleWord_r = 32'h0000_0000; // Filler while no word is sent

  // Straps are board resistors: a steady level
  assign powerClassStraps = strapCode;
  assign selfIdValid = sendReq;
  // Idle bus toggles, so a stale word can never pass as fresh
  assign selfIdWord = sendReq ? sendWord : idleWord_r;

  // Filler flips each idle cycle; a sent word loads its inverse
  always @(posedge clk) begin
    idleWord_r <= sendReq ? ~sendWord : ~idleWord_r;
  end
endmodule // pcds_far_side

`default_nettype wire

// file: testbench/test_power_class_default_select.sv
`timescale 1ns/100ps
`default_nettype none

module test_power_class_default_select;
  logic clk; // 100 MHz
  logic resetn; // Active low
  logic [2:0] strapCode; // Board strap setting
  logic pwrClassWrite;
  logic [2:0] pwrClassWrData;
  logic sendReq;
  logic [31:0] sendWord;
  logic [2:0] powerClassStraps;
  logic selfIdValid;
  logic [31:0] selfIdWord;
  logic selfIdOutValid;
  logic [31:0] selfIdOutWord;
  logic [2:0] powerClass;
  pcds_pkg::pcds_class_info_type classInfo;
  logic classLoaded;
  logic classFromSoftware;
  logic [31:0] expQ[$]; // Expected words, oldest first
  logic [2:0] expCode; // Code the bench expects active
  logic expSw; // Expect software origin
  logic [15:0] lfsrState; // Random source
  int n_fail;
  int cmp_count;

  pcds_far_side far (.clk(clk), .strapCode(strapCode), .sendReq(sendReq),
    .sendWord(sendWord), .powerClassStraps(powerClassStraps),
    .selfIdValid(selfIdValid), .selfIdWord(selfIdWord));

  power_class_default_select dut (.clk(clk), .resetn(resetn),
    .powerClassStraps(powerClassStraps), .pwrClassWrite(pwrClassWrite),
    .pwrClassWrData(pwrClassWrData), .selfIdValid(selfIdValid), .selfIdWord(selfIdWord),
    .selfIdOutValid(selfIdOutValid), .selfIdOutWord(selfIdOutWord),
    .powerClass(powerClass), .classInfo(classInfo), .classLoaded(classLoaded),
    .classFromSoftware(classFromSoftware));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Meaning of a code, built apart from the block's decoder
  function automatic pcds_pkg::pcds_class_info_type meaning(input logic [2:0] c);
    pcds_pkg::pcds_class_info_type m;
    m = '0; // Code 000 stays all zero
    if (c inside {3'h1, 3'h2, 3'h3}) begin
      m.selfPowered = 1'b1;
      m.repeatsPower = 1'b1;
      m.supplyMinW = 6'(c) * 6'h0f;
    end else if (c == 3'h4) begin
      m.busOptional = 1'b1;
    end else if (c != 3'h0) begin
      m.busPowered = 1'b1;
      m.linkExtraW = (c == 3'h5) ? 4'h0 : ((c == 3'h6) ? 4'h3 : 4'h7);
    end
    // Any bus-drawing code is capped at 3 W
    if (c[2]) begin
      m.needsPower = 1'b1;
      m.drawMaxW = 4'h3;
    end
    return m;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One cycle of stimulus; the word uses the code active before any write
  task automatic step(input logic wr, input logic [2:0] d, input logic snd,
      input logic [31:0] w);
    logic [31:0] e;
    @(posedge clk);
    pwrClassWrite <= wr;
    pwrClassWrData <= d;
    sendReq <= snd;
    sendWord <= w;
    e = w;
    e[10:8] = expCode;
    if (snd) begin
      expQ.push_back(e);
    end
    if (wr) begin
      expCode = d;
      expSw = 1'b1;
    end
  endtask

  // Idle cycle, then compare the active code and its meaning
  task automatic checkState();
    step(1'b0, 3'h0, 1'b0, 32'h0000_0000);
    @(negedge clk);
    check(32'(powerClass), 32'(expCode));
    check(32'(classInfo), 32'(meaning(expCode)));
    check(32'(classFromSoftware), 32'(expSw));
  endtask

  // Reset with straps s, then move the straps away after the load edge
  task automatic doReset(input logic [2:0] s);
    @(posedge clk);
    resetn <= 1'b0;
    strapCode <= s;
    pwrClassWrite <= 1'b0;
    sendReq <= 1'b0;
    @(negedge clk);
    check(32'({powerClass, classLoaded}), 32'h0000_0000);
    @(posedge clk);
    resetn <= 1'b1;
    expCode = s;
    expSw = 1'b0;
    @(posedge clk);
    strapCode <= ~s;
    @(negedge clk);
    check(32'({powerClass, classLoaded}), 32'({s, 1'b1}));
  endtask

  // Scoreboard: each word out is matched to the oldest note
  always @(negedge clk) begin
    if (selfIdOutValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check(32'h0000_0001, 32'h0000_0000);
      end else begin
        check(selfIdOutWord, expQ.pop_front());
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    resetn = 1'b0;
    strapCode = 3'h5;
    pwrClassWrite = 1'b0;
    pwrClassWrData = 3'h0;
    sendReq = 1'b0;
    sendWord = 32'h0000_0000;
    n_fail = 0;
    cmp_count = 0;
    expCode = 3'h0;
    expSw = 1'b0;
    lfsrState = 16'h9d53;
    repeat (16) @(posedge clk);
    // Every strap code loaded by reset and carried in a word
    for (int i = 0; i < 8; i++) begin
      doReset(3'(i));
      step(1'b0, 3'h0, 1'b1, 32'hffff_ffff);
      checkState();
    end
    $display("Test strap load done");
    // Every code written, with words on both sides of the write
    for (int i = 7; i >= 0; i--) begin
      step(1'b1, 3'(i), 1'b1, 32'h0000_0000);
      step(1'b0, 3'h0, 1'b1, 32'hffff_ffff);
      checkState();
    end
    $display("Test software write done");
    // Random back-to-back writes and words
    for (int i = 0; i < 200; i++) begin
      lfsrState = lfsr(lfsrState);
      step(lfsrState[0], lfsrState[3:1], lfsrState[4], {lfsrState, lfsr(lfsrState)});
    end
    checkState();
    $display("Test random traffic done");
    // Value holds through a quiet spell; reset restores the straps
    repeat (20) step(1'b0, 3'h0, 1'b0, 32'h0000_0000);
    checkState();
    doReset(3'h6);
    checkState();
    // Write on the strap-load edge beats the straps
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    pwrClassWrite <= 1'b1;
    pwrClassWrData <= 3'h2;
    expCode = 3'h2;
    expSw = 1'b1;
    checkState();
    check(32'(expQ.size()), 32'h0000_0000);
    $display("Test hold and reset done");
    summarize();
  end
endmodule // test_power_class_default_select

`default_nettype wire
